//--- logic/tbi_pkg.sv
// Shared constants and types for the touch baseline controller and its host.
// Assumes both ends run on one 10 MHz core clock.
package tbi_pkg;
   // ==========================================================================
   // Bus and key geometry
   localparam int          TBI_NKEY        = 8;
   localparam logic [6:0]  TBI_SLAVE_ADDR  = 7'h3C;
   localparam logic [3:0]  TBI_BYTE_BITS   = 4'h8;
   localparam logic [7:0]  TBI_SIG_MAX     = 8'hFE;
   localparam logic [7:0]  TBI_SIG_NOISE   = 8'hFF;
   // ==========================================================================
   // Register offsets
   localparam logic [7:0]  TBI_OFF_STATUS  = 8'h07;
   localparam logic [7:0]  TBI_OFF_SIGNAL  = 8'h09;
   localparam logic [7:0]  TBI_OFF_RAW     = 8'h11;
   localparam logic [7:0]  TBI_OFF_BASE    = 8'h21;
   localparam logic [7:0]  TBI_OFF_FTH     = 8'h31;
   localparam logic [7:0]  TBI_OFF_NTH     = 8'h39;
   localparam logic [7:0]  TBI_OFF_NNTH    = 8'h41;
   localparam logic [7:0]  TBI_OFF_LBR     = 8'h49;
   localparam logic [7:0]  TBI_OFF_INTEN   = 8'h61;
   localparam logic [7:0]  TBI_OFF_LOCK_HI = 8'h74;
   localparam logic [7:0]  TBI_OFF_LOCK_LO = 8'h75;
   // ==========================================================================
   // Values after reset
   localparam logic [7:0]  TBI_RST_FTH     = 8'h50;
   localparam logic [7:0]  TBI_RST_NTH     = 8'h28;
   localparam logic [7:0]  TBI_RST_NNTH    = 8'h28;
   localparam logic [7:0]  TBI_RST_LBR     = 8'h1E;
   localparam logic [7:0]  TBI_RST_INTEN   = 8'h00;
   localparam logic [7:0]  TBI_RST_LOCK_HI = 8'h03;
   localparam logic [7:0]  TBI_RST_LOCK_LO = 8'hE8;
   // ==========================================================================
   // Timing: one SCL period is four quarter phases of the host sequencer.
   localparam int          TBI_CLK_NS      = 100;
   localparam int          TBI_SCL_NS      = 2500;
   localparam int          TBI_QTR_INT     = (TBI_SCL_NS + 4 * TBI_CLK_NS - 1) / (4 * TBI_CLK_NS);
   localparam logic [3:0]  TBI_QTR_CYC     = 4'(TBI_QTR_INT);
   // ==========================================================================
   // State types
   typedef enum logic [3:0] {
      TBI_S_IDLE, TBI_S_DEV, TBI_S_DEVACK, TBI_S_REG, TBI_S_REGACK,
      TBI_S_WR, TBI_S_WRACK, TBI_S_RD, TBI_S_RDACK
   } tbi_dev_e;
   typedef enum logic [3:0] {
      TBI_P_IDLE, TBI_P_START, TBI_P_DEVW, TBI_P_REG, TBI_P_WDATA,
      TBI_P_RSTART, TBI_P_DEVR, TBI_P_RDATA, TBI_P_STOP
   } tbi_phase_e;
endpackage

//--- logic/tbi_bus_if.sv
// Two-wire bus between the host and the touch controller.
// SDA is open drain: the resolved level is low while either end pulls it.
`timescale 1ns/10ps
interface tbi_bus_if;
   logic scl;
   logic sda;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;

   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
   modport dev  (input scl, output dev_sda_o, output dev_sda_oe, input sda);
endinterface

//--- logic/tbi_device.sv
// Touch controller core: two-wire slave port, per-key baseline tracking and
// an active-low interrupt. Assumes raw counts arrive on the core clock with a
// one-cycle scan strobe; SCL and SDA come from outside and are synchronised.
`timescale 1ns/10ps
module tbi_device
   import tbi_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   tbi_bus_if.dev                     bus,
   input  wire logic [7:0][15:0]      raw_count,
   input  wire logic                  scan_strobe,
   output logic      [7:0]            key_status,
   output logic                       int_n
);
   // ==========================================================================
   // Pin synchronisers and bus conditions
   logic [2:0]       scl_q;
   logic [2:0]       sda_q;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_seen;
   logic             stop_seen;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end else if (ce) begin
         scl_q <= {scl_q[1:0], bus.scl};
         sda_q <= {sda_q[1:0], bus.sda};
      end
   end
   assign scl_rise   = scl_q[1] && !scl_q[2];
   assign scl_fall   = !scl_q[1] && scl_q[2];
   assign start_seen = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
   assign stop_seen  = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
   // ==========================================================================
   // Slave protocol engine
   tbi_dev_e         st_q;
   logic [3:0]       cnt_q;
   logic [7:0]       shift_q;
   logic [7:0]       tx_q;
   logic [7:0]       ptr_q;
   logic             oe_q;
   logic             mack_q;
   logic [7:0]       rdata;
   logic             wr_fire;
   logic             rd_load;
   assign bus.dev_sda_o  = 1'b0;
   assign bus.dev_sda_oe = oe_q;
   assign wr_fire = ce && scl_fall && st_q == TBI_S_WR && cnt_q == TBI_BYTE_BITS;
   assign rd_load = ce && scl_fall
                    && ((st_q == TBI_S_DEVACK && shift_q[0]) || (st_q == TBI_S_RDACK && mack_q));
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         st_q    <= TBI_S_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         tx_q    <= 8'h00;
         ptr_q   <= 8'h00;
         oe_q    <= 1'b0;
         mack_q  <= 1'b0;
      end else if (ce) begin
         if (start_seen) begin
            st_q  <= TBI_S_DEV;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
         end else if (stop_seen) begin
            st_q <= TBI_S_IDLE;
            oe_q <= 1'b0;
         end else if (scl_rise) begin
            unique case (st_q)
               TBI_S_DEV, TBI_S_REG, TBI_S_WR: begin
                  shift_q <= {shift_q[6:0], sda_q[1]};
                  cnt_q   <= cnt_q + 4'h1;
               end
               TBI_S_RDACK: mack_q <= !sda_q[1];
               default: ;
            endcase
         end else if (scl_fall) begin
            unique case (st_q)
               TBI_S_DEV: if (cnt_q == TBI_BYTE_BITS) begin
                  st_q <= (shift_q[7:1] == TBI_SLAVE_ADDR) ? TBI_S_DEVACK : TBI_S_IDLE;
                  oe_q <= shift_q[7:1] == TBI_SLAVE_ADDR;
               end
               TBI_S_DEVACK: begin
                  cnt_q <= 4'h0;
                  st_q  <= shift_q[0] ? TBI_S_RD : TBI_S_REG;
                  tx_q  <= rdata;
                  oe_q  <= shift_q[0] && !rdata[7];
               end
               TBI_S_REG: if (cnt_q == TBI_BYTE_BITS) begin
                  ptr_q <= shift_q;
                  st_q  <= TBI_S_REGACK;
                  oe_q  <= 1'b1;
               end
               TBI_S_REGACK, TBI_S_WRACK: begin
                  ptr_q <= ptr_q + {7'h00, st_q == TBI_S_WRACK};
                  st_q  <= TBI_S_WR;
                  cnt_q <= 4'h0;
                  oe_q  <= 1'b0;
               end
               TBI_S_WR: if (cnt_q == TBI_BYTE_BITS) begin
                  st_q <= TBI_S_WRACK;
                  oe_q <= 1'b1;
               end
               TBI_S_RD: begin
                  if (cnt_q == 4'h7) begin
                     st_q  <= TBI_S_RDACK;
                     oe_q  <= 1'b0;
                     ptr_q <= ptr_q + 8'h01;
                  end else begin
                     tx_q  <= {tx_q[6:0], 1'b0};
                     oe_q  <= !tx_q[6];
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               TBI_S_RDACK: begin
                  cnt_q <= 4'h0;
                  st_q  <= mack_q ? TBI_S_RD : TBI_S_IDLE;
                  tx_q  <= rdata;
                  oe_q  <= mack_q && !rdata[7];
               end
               TBI_S_IDLE: ;
            endcase
         end
      end
   end

   // ==========================================================================
   // Configuration bytes
   // Only the threshold, low-baseline limit, enable and lock bytes are writable; all other
   // addresses keep their reset value and ignore writes.
   logic [7:0]       cfg_q [256];
   function automatic logic [7:0] cfg_default(input logic [7:0] a);
      if (a >= TBI_OFF_FTH && a < TBI_OFF_NTH) return TBI_RST_FTH;
      if (a >= TBI_OFF_NTH && a < TBI_OFF_NNTH) return TBI_RST_NTH;
      if (a >= TBI_OFF_NNTH && a < TBI_OFF_LBR) return TBI_RST_NNTH;
      if (a >= TBI_OFF_LBR && a < TBI_OFF_LBR + 8'h08) return TBI_RST_LBR;
      if (a == TBI_OFF_INTEN) return TBI_RST_INTEN;
      if (a == TBI_OFF_LOCK_HI) return TBI_RST_LOCK_HI;
      if (a == TBI_OFF_LOCK_LO) return TBI_RST_LOCK_LO;
      return 8'h00;
   endfunction
   function automatic logic cfg_writable(input logic [7:0] a);
      return (a >= TBI_OFF_FTH && a < TBI_OFF_LBR + 8'h08) || a == TBI_OFF_INTEN
             || a == TBI_OFF_LOCK_HI || a == TBI_OFF_LOCK_LO;
   endfunction
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 256; i++) begin
            cfg_q[i] <= cfg_default(8'(i));
         end
      end else if (wr_fire && cfg_writable(ptr_q)) begin
         cfg_q[ptr_q] <= shift_q;
      end
   end

   // ==========================================================================
   // Per-key baseline tracking
   logic [15:0]      base_q [TBI_NKEY];
   logic [7:0]       lbc_q  [TBI_NKEY];
   logic [7:0]       sig    [TBI_NKEY];
   logic [7:0]       stat_q;
   logic [7:0]       stat_d;
   logic [15:0]      lock_th;
   assign lock_th = {cfg_q[TBI_OFF_LOCK_HI], cfg_q[TBI_OFF_LOCK_LO]};
   for (genvar k = 0; k < TBI_NKEY; k++) begin : g_key
      logic [16:0] diff;
      logic        neg;
      logic [15:0] mag;
      logic        locked;
      logic [7:0]  nth;
      logic [7:0]  nnth;
      logic [7:0]  lbr;
      logic [7:0]  lbc_inc;
      assign diff    = {1'b0, base_q[k]} - {1'b0, raw_count[k]};
      assign neg     = diff[16];
      assign mag     = neg ? 16'(-diff) : diff[15:0];
      assign nth     = cfg_q[TBI_OFF_NTH + 8'(k)];
      assign nnth    = cfg_q[TBI_OFF_NNTH + 8'(k)];
      assign lbr     = cfg_q[TBI_OFF_LBR + 8'(k)];
      assign locked  = !neg && mag > lock_th;
      assign lbc_inc = (lbc_q[k] == 8'hFF) ? lbc_q[k] : lbc_q[k] + 8'h01;
      assign stat_d[k] = !neg && !locked && mag >= {8'h00, cfg_q[TBI_OFF_FTH + 8'(k)]};
      // Raw above baseline by more than the negative margin reads as noise.
      assign sig[k]  = neg ? ((mag > {8'h00, nnth}) ? TBI_SIG_NOISE : 8'h00)
                           : ((mag > {8'h00, TBI_SIG_MAX}) ? TBI_SIG_MAX : mag[7:0]);
      always_ff @(posedge core_clk) begin
         if (!resetn) begin
            base_q[k] <= 16'h0000;
            lbc_q[k]  <= 8'h00;
         end else if (ce && scan_strobe && !locked) begin
            if (mag > {8'h00, nnth}) begin
               if (lbc_inc > lbr) begin
                  base_q[k] <= raw_count[k];
                  lbc_q[k]  <= 8'h00;
               end else begin
                  lbc_q[k] <= lbc_inc;
               end
            end else begin
               lbc_q[k] <= 8'h00;
            end
            if (neg || mag < {8'h00, nth}) begin
               base_q[k] <= raw_count[k];
            end
         end
      end
   end

   // ==========================================================================
   // Key status and interrupt
   // A new touch wins over the clear caused by reading the status byte.
   logic [7:0]       flag_q;
   logic             int_n_q;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         stat_q  <= 8'h00;
         flag_q  <= 8'h00;
         int_n_q <= 1'b1;
      end else if (ce) begin
         if (scan_strobe) begin
            stat_q <= stat_d;
         end
         flag_q <= ((rd_load && ptr_q == TBI_OFF_STATUS) ? 8'h00 : flag_q)
                   | ((scan_strobe ? (stat_d & ~stat_q) : 8'h00) & cfg_q[TBI_OFF_INTEN]);
         int_n_q <= !(|flag_q);
      end
   end
   assign key_status = stat_q;
   assign int_n      = int_n_q;
   // ==========================================================================
   // Read data selection
   always_comb begin
      logic [7:0] off;
      off   = 8'h00;
      rdata = cfg_q[ptr_q];
      if (ptr_q == TBI_OFF_STATUS) begin
         rdata = stat_q;
      end else if (ptr_q >= TBI_OFF_SIGNAL && ptr_q < TBI_OFF_RAW) begin
         off   = ptr_q - TBI_OFF_SIGNAL;
         rdata = sig[off[2:0]];
      end else if (ptr_q >= TBI_OFF_RAW && ptr_q < TBI_OFF_BASE) begin
         off   = ptr_q - TBI_OFF_RAW;
         rdata = off[0] ? raw_count[off[3:1]][7:0] : raw_count[off[3:1]][15:8];
      end else if (ptr_q >= TBI_OFF_BASE && ptr_q < TBI_OFF_FTH) begin
         off   = ptr_q - TBI_OFF_BASE;
         rdata = off[0] ? base_q[off[3:1]][7:0] : base_q[off[3:1]][15:8];
      end
   end
endmodule

//--- logic/tbi_host.sv
// Host end of the two-wire bus: writes one byte or reads a run of bytes.
// Assumes the device is the only slave and never stretches SCL.
`timescale 1ns/10ps
module tbi_host
   import tbi_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic                  ce,
   tbi_bus_if.host                    bus,
   input  wire logic                  req,
   input  wire logic                  rd,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            wdata,
   input  wire logic [3:0]            rlen,
   output logic                       busy,
   output logic                       rvalid,
   output logic      [7:0]            rdata,
   output logic                       nack,
   output logic                       done
);
   // ==========================================================================
   // Quarter-phase timebase and SDA synchroniser
   logic [3:0]       tick_q;
   logic [1:0]       sda_q;
   logic             tick;

   assign tick = ce && tick_q == TBI_QTR_CYC - 4'h1;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         tick_q <= 4'h0;
         sda_q  <= 2'h3;
      end else if (ce) begin
         tick_q <= tick ? 4'h0 : tick_q + 4'h1;
         sda_q  <= {sda_q[0], bus.sda};
      end
   end

   // ==========================================================================
   // Phase sequencer
   tbi_phase_e       ph_q;
   logic [1:0]       q_q;
   logic [3:0]       b_q;
   logic [7:0]       tx_q;
   logic [7:0]       rx_q;
   logic [3:0]       left_q;
   logic [7:0]       reg_q;
   logic [7:0]       wd_q;
   logic             rd_q;
   logic             scl_q;
   logic             oe_q;
   logic             ackd_q;
   logic             rcv;

   // Receiving data bytes; every other byte is sent by the host.
   assign rcv = ph_q == TBI_P_RDATA;
   assign bus.scl         = scl_q;
   assign bus.host_sda_o  = 1'b0;
   assign bus.host_sda_oe = oe_q;
   assign busy = ph_q != TBI_P_IDLE;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         ph_q   <= TBI_P_IDLE;
         q_q    <= 2'h0;
         b_q    <= 4'h0;
         tx_q   <= 8'h00;
         rx_q   <= 8'h00;
         left_q <= 4'h0;
         reg_q  <= 8'h00;
         wd_q   <= 8'h00;
         rd_q   <= 1'b0;
         scl_q  <= 1'b1;
         oe_q   <= 1'b0;
         ackd_q <= 1'b0;
         rvalid <= 1'b0;
         rdata  <= 8'h00;
         nack   <= 1'b0;
         done   <= 1'b0;
      end else if (ce) begin
         rvalid <= 1'b0;
         nack   <= 1'b0;
         done   <= 1'b0;
         if (ph_q == TBI_P_IDLE) begin
            q_q <= 2'h0;
            if (req) begin
               ph_q   <= TBI_P_START;
               rd_q   <= rd;
               reg_q  <= reg_addr;
               wd_q   <= wdata;
               left_q <= (rlen == 4'h0) ? 4'h1 : rlen;
            end
         end else if (tick) begin
            q_q <= q_q + 2'h1;
            unique case (ph_q)
               TBI_P_START, TBI_P_RSTART: begin
                  unique case (q_q)
                     2'h0: oe_q  <= 1'b0;
                     2'h1: scl_q <= 1'b1;
                     2'h2: oe_q  <= 1'b1;
                     2'h3: begin
                        scl_q <= 1'b0;
                        b_q   <= 4'h0;
                        ph_q  <= (ph_q == TBI_P_START) ? TBI_P_DEVW : TBI_P_DEVR;
                        tx_q  <= {TBI_SLAVE_ADDR, ph_q == TBI_P_RSTART};
                     end
                  endcase
               end
               TBI_P_STOP: begin
                  unique case (q_q)
                     2'h0: oe_q  <= 1'b1;
                     2'h1: scl_q <= 1'b1;
                     2'h2: oe_q  <= 1'b0;
                     2'h3: begin
                        ph_q <= TBI_P_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
               default: begin
                  unique case (q_q)
                     2'h0: begin
                        if (b_q == TBI_BYTE_BITS) begin
                           oe_q <= rcv && left_q != 4'h1;
                        end else begin
                           oe_q <= !rcv && !tx_q[7];
                        end
                     end
                     2'h1: scl_q <= 1'b1;
                     2'h2: begin
                        if (b_q == TBI_BYTE_BITS) begin
                           ackd_q <= !sda_q[1];
                        end else begin
                           rx_q <= {rx_q[6:0], sda_q[1]};
                        end
                     end
                     2'h3: begin
                        scl_q <= 1'b0;
                        b_q   <= b_q + 4'h1;
                        if (b_q != TBI_BYTE_BITS) begin
                           tx_q <= {tx_q[6:0], 1'b0};
                        end else begin
                           b_q <= 4'h0;
                           q_q <= 2'h0;
                           if (rcv) begin
                              rvalid <= 1'b1;
                              rdata  <= rx_q;
                              left_q <= left_q - 4'h1;
                              ph_q   <= (left_q == 4'h1) ? TBI_P_STOP : TBI_P_RDATA;
                           end else if (!ackd_q) begin
                              nack <= 1'b1;
                              ph_q <= TBI_P_STOP;
                           end else begin
                              unique case (ph_q)
                                 TBI_P_DEVW: begin
                                    ph_q <= TBI_P_REG;
                                    tx_q <= reg_q;
                                 end
                                 TBI_P_REG: begin
                                    ph_q <= rd_q ? TBI_P_RSTART : TBI_P_WDATA;
                                    tx_q <= wd_q;
                                 end
                                 TBI_P_DEVR: ph_q <= TBI_P_RDATA;
                                 default: ph_q <= TBI_P_STOP;
                              endcase
                           end
                        end
                     end
                  endcase
               end
            endcase
         end
      end
   end
endmodule

//--- dv/tbi_monitor.sv
// Concurrent checks on the two-wire bus between host and touch controller.
// Assumes the signals of one tbi_bus_if and the shared core clock and reset.
`timescale 1ns/10ps
module tbi_monitor (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   // ==========================================================================
   // Bus timing and ownership
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_reset_bus_idle: assert property (disable iff (1'b0)
      !resetn |=> scl && !host_sda_oe && !dev_sda_oe) else $error("bus not idle in reset");
   a_dev_scl_low: assert property (
      $changed(dev_sda_oe) |-> !scl && $past(scl, 8)) else $error("device SDA moved late");
   a_dev_bit_stands: assert property (
      $rose(dev_sda_oe) |-> dev_sda_oe[*8]) else $error("device pull too short");
   a_no_contention: assert property (
      dev_sda_oe && scl |-> !host_sda_oe) else $error("host drives during device bit");
   a_scl_high_min: assert property (
      $rose(scl) |-> scl[*8]) else $error("SCL high too short");
   a_scl_low_min: assert property (
      $fell(scl) |-> !scl[*8]) else $error("SCL low too short");
   a_start_hold: assert property (
      scl && $fell(sda) |-> scl[*3]) else $error("start not held");
   a_stop_idle: assert property (
      scl && $rose(sda) |-> sda[*8]) else $error("bus not idle after stop");
   a_wire_level: assert property (
      sda == !(host_sda_oe || dev_sda_oe)) else $error("SDA level wrong");
endmodule

//--- dv/testbench.sv
// Self-checking bench: host and touch controller joined by tbi_bus_if.
// Assumes both design ends and the monitor are compiled before this file.
`timescale 1ns/10ps
module testbench;
   import tbi_pkg::*;
   logic             core_clk = 1'b0;
   logic             resetn = 1'b0;
   logic             req = 1'b0;
   logic             rd = 1'b0;
   logic             ce = 1'b1;
   logic             scan_strobe = 1'b0;
   logic [7:0]       reg_addr = 8'h00;
   logic [7:0]       wdata = 8'h00;
   logic [3:0]       rlen = 4'h0;
   logic [7:0][15:0] raw_count = '0;
   logic [15:0]      seed = 16'h005B;
   logic [15:0]      base;
   logic [7:0]       rq[$];
   logic             busy, rvalid, nack, done, int_n;
   logic [7:0]       rdata, key_status;
   int               mismatches = 0;
   int               checked = 0;
   tbi_bus_if bus ();
   tbi_device i_tbi_device (.core_clk(core_clk), .resetn(resetn), .ce(ce), .bus(bus),
      .raw_count(raw_count), .scan_strobe(scan_strobe), .key_status(key_status), .int_n(int_n));
   tbi_host i_tbi_host (.core_clk(core_clk), .resetn(resetn), .ce(ce), .bus(bus),
      .req(req), .rd(rd), .reg_addr(reg_addr), .wdata(wdata), .rlen(rlen), .busy(busy),
      .rvalid(rvalid), .rdata(rdata), .nack(nack), .done(done));
   tbi_monitor i_tbi_monitor (.core_clk(core_clk), .resetn(resetn), .scl(bus.scl),
      .sda(bus.sda), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));
   always #50 core_clk = !core_clk;
   // ==========================================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (rvalid === 1'b1) rq.push_back(rdata);
      if (nack === 1'b1) check("nack", 16'h0001, 16'h0000);
   end
   task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] w,
                       input logic [3:0] n);
      rq.delete();
      req <= 1'b1; rd <= r; reg_addr <= a; wdata <= w; rlen <= n;
      @(posedge core_clk);
      req <= 1'b0;
      for (int i = 0; i < 30000 && done !== 1'b1; i++) @(posedge core_clk);
      check("done", done, 16'h0001);
      @(posedge core_clk);
      check("busy", busy, 16'h0000);
   endtask
   task automatic rdk(input logic [7:0] a, input logic [3:0] n, input logic [7:0] e);
      xfer(1'b1, a, 8'h00, n);
      check("count", 16'(rq.size()), 16'(n));
      for (int i = 0; i < n; i++) check("rdata", rq[i], e);
   endtask
   // Key 2 sits beyond the lock distance in every scan after the first two.
   task automatic scan(input logic [15:0] d0, input logic [15:0] d1, input logic [15:0] d2);
      raw_count <= {{5{base}}, base - d2, base - d1, base - d0};
      scan_strobe <= 1'b1;
      @(posedge core_clk);
      scan_strobe <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic rdbase(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b1, a, 8'h00, 4'h2);
      check("baseline", {rq[0], rq[1]}, e);
   endtask
   // ==========================================================================
   // Scenarios
   initial begin
      repeat (80000) @(posedge core_clk);
      mismatches++;
      complete_run;
   end
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rdk(TBI_OFF_FTH, 4'h8, TBI_RST_FTH);
      rdk(TBI_OFF_NTH, 4'h8, TBI_RST_NTH);
      rdk(TBI_OFF_LBR, 4'h8, TBI_RST_LBR);
      xfer(1'b1, TBI_OFF_LOCK_HI, 8'h00, 4'h2);
      check("lock", {rq[0], rq[1]}, {TBI_RST_LOCK_HI, TBI_RST_LOCK_LO});
      seed = lfsr(seed);
      xfer(1'b0, TBI_OFF_FTH + 8'h07, seed[7:0], 4'h1);
      xfer(1'b1, TBI_OFF_FTH + 8'h07, 8'h00, 4'h2);
      check("write", {rq[0], rq[1]}, {seed[7:0], TBI_RST_NTH});
      seed = lfsr(seed);
      base = 16'h1000 | {4'h0, seed[11:0]};
      scan(16'h0000, 16'h0000, 16'h0000);
      // The first scan also counts once, as raw starts far from a zero baseline.
      // A quiet second scan clears every low-baseline counter again.
      scan(16'h0000, 16'h0000, 16'h0000);
      rdbase(TBI_OFF_BASE, base);
      xfer(1'b0, TBI_OFF_LBR, 8'h02, 4'h1);
      xfer(1'b0, TBI_OFF_NTH, 8'h10, 4'h1);
      xfer(1'b0, TBI_OFF_INTEN, 8'h02, 4'h1);
      scan(16'h0030, 16'h0060, 16'h044C);
      scan(16'h0030, 16'h0060, 16'h044C);
      check("key_status", key_status, 8'h02);
      check("int_n low", int_n, 1'b0);
      xfer(1'b1, TBI_OFF_STATUS, 8'h00, 4'h4);
      check("status", rq[0], 8'h02);
      check("signal0", rq[2], 8'h30);
      check("signal1", rq[3], 8'h60);
      check("int_n high", int_n, 1'b1);
      scan(16'h0020, 16'h0060, 16'h044C);
      scan(16'h0030, 16'h0060, 16'h044C);
      scan(16'h0030, 16'h0060, 16'h044C);
      rdbase(TBI_OFF_BASE, base);
      scan(16'h0030, 16'h0060, 16'h044C);
      rdbase(TBI_OFF_BASE, base - 16'h0030);
      rdbase(TBI_OFF_BASE + 8'h02, base);
      rdbase(TBI_OFF_BASE + 8'h04, base);
      check("int_n held", int_n, 1'b1);
      // With the clock enable low, a count 0x30 below key 0's new baseline, short of a touch, must change nothing.
      ce <= 1'b0;
      scan(16'h0060, 16'h0060, 16'h044C);
      check("frozen", key_status, 8'h02);
      ce <= 1'b1;
      complete_run;
   end
endmodule
